/* src/mfe_top.sv */
// memory fault and bus event reporting unit with apb register slave
//
// Behaviour
// - protected reads correct single, flag double errors
// - hardware initializes ecc rams, reports done
// - ecc on after reset, only tcm switchable
// - tcm double ecc errors raise undefined exceptions
// - other ram errors set cause and interrupt
// - caches have byte parity, tags parity
// - icache or tag parity sets cause, interrupt
// - dcache or tag parity sets cause, interrupt
// - writing zero to cause register clears all
// - parity enables reset zero, gate checking
// - distinct gap interrupts per bus
// - bus gap latches address, master, type
// - module gap raises interrupt, captures details
// - itcm and dtcm gaps raise separate interrupts
// - pll out of range raises interrupt
// - refill bus error suppresses prefetch abort
// - five check bits per tcm byte
// - tcm init about 16.5 us, three flags
`timescale 1ns/1ps
module mfe_top
   import mfe_pkg::*;
#(
   parameter int INIT_CYCLES = MFE_INIT_CYC,
   parameter int BYTES = 4
)(
   input wire logic clk_i,
   input wire logic resetn_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // tcm read path
   input wire logic tcm_rd_i,
   input wire logic tcm_is_data_i,
   input wire logic [8*BYTES-1:0] tcm_rdata_i,
   input wire logic [MFE_CHK_W*BYTES-1:0] tcm_rchk_i,
   output logic [8*BYTES-1:0] tcm_fixed_o,
   output logic undef_instr_o,
   output logic undef_data_o,
   // other protected ram read path
   input wire logic ram_rd_i,
   input wire logic [8*BYTES-1:0] ram_rdata_i,
   input wire logic [MFE_CHK_W*BYTES-1:0] ram_rchk_i,
   output logic [8*BYTES-1:0] ram_fixed_o,
   // write-side check code generation
   input wire logic [8*BYTES-1:0] wdata_i,
   output logic [MFE_CHK_W*BYTES-1:0] wchk_o,
   // initialization sweep
   output logic init_we_o,
   output logic [15:0] init_addr_o,
   // cache parity
   input wire mfe_cache_rd_s icache_i,
   input wire mfe_cache_rd_s dcache_i,
   // gap monitors
   input wire mfe_gap_s ext_gap_i,
   input wire mfe_gap_s per_gap_i,
   input wire mfe_gap_s sys_gap_i,
   input wire mfe_gap_s mod_gap_i,
   input wire logic [3:0] mod_id_i,
   input wire logic itcm_gap_i,
   input wire logic dtcm_gap_i,
   // pll monitor
   input wire logic pll_out_of_range_i,
   input wire logic pll_lock_i,
   // instruction fetch abort filtering
   input wire logic abort_req_i,
   input wire logic refill_i,
   output logic prefetch_abort_o,
   // interrupts to the processor interrupt controller
   output logic memory_error_interrupt_o,
   output logic pll_loss_interrupt_o,
   output logic ext_mem_gap_interrupt_o,
   output logic periph_bus_gap_interrupt_o,
   output logic system_bus_gap_interrupt_o,
   output logic module_gap_interrupt_o,
   output logic itcm_gap_interrupt_o,
   output logic dtcm_gap_interrupt_o
);
   localparam int CNT_W = 16;
   // bus codes in the access-timeout info byte
   localparam logic [1:0] BUS_EXT = 2'h0;
   localparam logic [1:0] BUS_PER = 2'h1;
   localparam logic [1:0] BUS_SYS = 2'h2;

   // refuse settings that the sweep counter or the lane codecs cannot serve
   if (INIT_CYCLES < 1 || INIT_CYCLES >= (1 << CNT_W)) begin : g_bad_init
      $error("INIT_CYCLES out of range");
   end
   if (BYTES < 1 || BYTES > 4) begin : g_bad_bytes
      $error("BYTES must be 1 to 4");
   end

   typedef enum logic [1:0] {
      MFE_ST_INIT = 2'b00,
      MFE_ST_RUN = 2'b01
   } mfe_state_e;

   typedef struct packed {
      mfe_state_e state;
      logic [CNT_W-1:0] init_cnt;
      logic [MFE_INIT_W-1:0] init_done;
      logic [MFE_CAUSE_W-1:0] cause;
      logic [MFE_CTRL_W-1:0] ctrl;
      logic [MFE_GAP_W-1:0] gap;
      logic [31:0] to_addr;
      logic [7:0] to_info;
      logic [31:0] mod_addr;
      logic [7:0] mod_info;
      logic [31:0] rdata;
      logic slverr;
      logic und_i;
      logic und_d;
      logic [8*BYTES-1:0] tcm_fixed;
      logic [8*BYTES-1:0] ram_fixed;
   } mfe_st_s;

   mfe_st_s st_reg;
   mfe_st_s st_next;

   logic [8*BYTES-1:0] tcm_fix;
   logic [8*BYTES-1:0] ram_fix;
   logic [BYTES-1:0] tcm_sgl;
   logic [BYTES-1:0] tcm_dbl;
   logic [BYTES-1:0] ram_sgl;
   logic [BYTES-1:0] ram_dbl;

   // one codec per byte lane for each read path; write codes share the tcm lane
   for (genvar b = 0; b < BYTES; b++) begin : g_lane
      mfe_byte_edc u_tcm (
         .wdata_i(wdata_i[8*b +: 8]),
         .wchk_o(wchk_o[MFE_CHK_W*b +: MFE_CHK_W]),
         .rdata_i(tcm_rdata_i[8*b +: 8]),
         .rchk_i(tcm_rchk_i[MFE_CHK_W*b +: MFE_CHK_W]),
         .fixed_o(tcm_fix[8*b +: 8]),
         .single_o(tcm_sgl[b]),
         .double_o(tcm_dbl[b])
      );
      mfe_byte_edc u_ram (
         .wdata_i(wdata_i[8*b +: 8]),
         .wchk_o(),
         .rdata_i(ram_rdata_i[8*b +: 8]),
         .rchk_i(ram_rchk_i[MFE_CHK_W*b +: MFE_CHK_W]),
         .fixed_o(ram_fix[8*b +: 8]),
         .single_o(ram_sgl[b]),
         .double_o(ram_dbl[b])
      );
   end

   logic apb_setup;
   logic apb_wr;
   logic wr_cause;
   logic wr_ctrl;
   logic wr_gap;
   logic tcm_edc_on;
   logic ic_err;
   logic it_err;
   logic dc_err;
   logic dt_err;
   logic itag_bad;
   logic dtag_bad;
   logic tcm_dbl_any;
   logic ram_sgl_any;
   logic ram_dbl_any;
   logic abort_hidden;

   assign apb_setup = psel_i && !penable_i;
   assign apb_wr = psel_i && penable_i && pwrite_i;
   // writes land at the access edge; pready never stalls the master
   assign wr_cause = apb_wr && paddr_i == MFE_CAUSE_OFS;
   assign wr_ctrl = apb_wr && paddr_i == MFE_CTRL_OFS;
   assign wr_gap = apb_wr && paddr_i == MFE_GAP_OFS;
   assign tcm_edc_on = !st_reg.ctrl[MFE_E_TCM_OFF];
   // any lane error flags the whole word
   assign tcm_dbl_any = tcm_edc_on && (|tcm_dbl);
   assign ram_sgl_any = ram_rd_i && (|ram_sgl);
   assign ram_dbl_any = ram_rd_i && (|ram_dbl);
   assign itag_bad = (^icache_i.tag) ^ icache_i.tag_par;
   assign dtag_bad = (^dcache_i.tag) ^ dcache_i.tag_par;
   // a refill that ran into a system bus gap is reported by interrupt only
   assign abort_hidden = refill_i && sys_gap_i.valid;

   // byte parity is even per lane, tag carries one even parity bit
   always_comb begin
      logic [3:0] ip;
      logic [3:0] dp;
      ip = 4'h0;
      dp = 4'h0;
      for (int i = 0; i < 4; i++) begin
         ip[i] = ^icache_i.data[8*i +: 8] ^ icache_i.par[i];
         dp[i] = ^dcache_i.data[8*i +: 8] ^ dcache_i.par[i];
      end
      ic_err = st_reg.ctrl[MFE_E_IPAR] && icache_i.valid && (|ip);
      it_err = st_reg.ctrl[MFE_E_IPAR] && icache_i.tag_valid && itag_bad;
      dc_err = st_reg.ctrl[MFE_E_DPAR] && dcache_i.valid && (|dp);
      dt_err = st_reg.ctrl[MFE_E_DPAR] && dcache_i.tag_valid && dtag_bad;
   end

   always_comb begin
      logic [MFE_CAUSE_W-1:0] cause_set;
      logic [MFE_GAP_W-1:0] gap_set;
      st_next = st_reg;
      cause_set = '0;
      gap_set = '0;

      // initialization sweep over the protected rams
      case (st_reg.state)
         MFE_ST_INIT: begin
            if (st_reg.init_cnt == CNT_W'(INIT_CYCLES - 1)) begin
               st_next.state = MFE_ST_RUN;
               st_next.init_done = '1;
            end else begin
               st_next.init_cnt = st_reg.init_cnt + CNT_W'(1);
            end
         end
         MFE_ST_RUN: begin
            // sweep address parks on its last value
            st_next.init_cnt = st_reg.init_cnt;
         end
         default: begin
            st_next.state = MFE_ST_INIT;
         end
      endcase

      // tcm errors go to the core as exceptions, not to the cause register
      // tcm single errors are fixed silently; only double errors trap
      st_next.tcm_fixed = tcm_edc_on ? tcm_fix : tcm_rdata_i;
      st_next.und_i = tcm_rd_i && !tcm_is_data_i && tcm_dbl_any;
      st_next.und_d = tcm_rd_i && tcm_is_data_i && tcm_dbl_any;

      // other rams cannot be switched off
      st_next.ram_fixed = ram_fix;
      cause_set[MFE_C_RAM_1B] = ram_sgl_any;
      cause_set[MFE_C_RAM_2B] = ram_dbl_any;
      cause_set[MFE_C_ICACHE] = ic_err;
      cause_set[MFE_C_ITAG] = it_err;
      cause_set[MFE_C_DCACHE] = dc_err;
      cause_set[MFE_C_DTAG] = dt_err;

      gap_set[MFE_G_EXT] = ext_gap_i.valid;
      gap_set[MFE_G_PER] = per_gap_i.valid;
      gap_set[MFE_G_SYS] = sys_gap_i.valid;
      gap_set[MFE_G_MOD] = mod_gap_i.valid;
      gap_set[MFE_G_ITCM] = itcm_gap_i;
      gap_set[MFE_G_DTCM] = dtcm_gap_i;

      // latest bus gap wins; system bus ranks over peripheral over external
      if (sys_gap_i.valid) begin
         st_next.to_addr = sys_gap_i.addr;
         st_next.to_info = {BUS_SYS, sys_gap_i.write, 1'b0, sys_gap_i.master};
      end else if (per_gap_i.valid) begin
         st_next.to_addr = per_gap_i.addr;
         st_next.to_info = {BUS_PER, per_gap_i.write, 1'b0, per_gap_i.master};
      end else if (ext_gap_i.valid) begin
         st_next.to_addr = ext_gap_i.addr;
         st_next.to_info = {BUS_EXT, ext_gap_i.write, 1'b0, ext_gap_i.master};
      end
      if (mod_gap_i.valid) begin
         st_next.mod_addr = mod_gap_i.addr;
         st_next.mod_info = {mod_id_i, mod_gap_i.write, 3'h0};
      end

      // apb: read data captured in setup, answered in the access phase
      if (apb_setup) begin
         st_next.slverr = 1'b0;
         st_next.rdata = 32'h0000_0000;
         if (paddr_i == MFE_CAUSE_OFS) begin
            st_next.rdata = 32'(st_reg.cause);
         end else if (paddr_i == MFE_CTRL_OFS) begin
            st_next.rdata = 32'(st_reg.ctrl);
         end else if (paddr_i == MFE_INIT_OFS) begin
            st_next.rdata = 32'(st_reg.init_done);
         end else if (paddr_i == MFE_GAP_OFS) begin
            st_next.rdata = 32'(st_reg.gap);
         end else if (paddr_i == MFE_TO_ADDR_OFS) begin
            st_next.rdata = st_reg.to_addr;
         end else if (paddr_i == MFE_TO_INFO_OFS) begin
            st_next.rdata = 32'(st_reg.to_info);
         end else if (paddr_i == MFE_MOD_ADDR_OFS) begin
            st_next.rdata = st_reg.mod_addr;
         end else if (paddr_i == MFE_MOD_INFO_OFS) begin
            st_next.rdata = 32'(st_reg.mod_info);
         end else if (paddr_i == MFE_PLL_OFS) begin
            st_next.rdata = {30'h0000_0000, pll_out_of_range_i, pll_lock_i};
         end else begin
            st_next.slverr = 1'b1;
         end
      end

      if (wr_cause && pwdata_i == 32'h0000_0000) begin
         st_next.cause = '0;
      end
      if (wr_ctrl) begin
         st_next.ctrl = pwdata_i[MFE_CTRL_W-1:0];
      end
      if (wr_gap) begin
         st_next.gap = st_next.gap & ~pwdata_i[MFE_GAP_W-1:0];
      end
      // new events win over a clear in the same cycle
      st_next.cause = st_next.cause | cause_set;
      st_next.gap = st_next.gap | gap_set;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_reg <= '0;
         st_reg.state <= MFE_ST_INIT;
         st_reg.ctrl <= MFE_CTRL_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata_o = st_reg.rdata;
   assign pready_o = 1'b1;
   // error shown only in the access phase, so a setup cycle never sees it
   assign pslverr_o = psel_i && penable_i && st_reg.slverr;
   assign tcm_fixed_o = st_reg.tcm_fixed;
   assign ram_fixed_o = st_reg.ram_fixed;
   assign undef_instr_o = st_reg.und_i;
   assign undef_data_o = st_reg.und_d;
   assign init_we_o = (st_reg.state == MFE_ST_INIT);
   assign init_addr_o = st_reg.init_cnt;
   assign memory_error_interrupt_o = |st_reg.cause;
   assign pll_loss_interrupt_o = pll_out_of_range_i;
   assign ext_mem_gap_interrupt_o = st_reg.gap[MFE_G_EXT];
   assign periph_bus_gap_interrupt_o = st_reg.gap[MFE_G_PER];
   assign system_bus_gap_interrupt_o = st_reg.gap[MFE_G_SYS];
   assign module_gap_interrupt_o = st_reg.gap[MFE_G_MOD];
   assign itcm_gap_interrupt_o = st_reg.gap[MFE_G_ITCM];
   assign dtcm_gap_interrupt_o = st_reg.gap[MFE_G_DTCM];
   assign prefetch_abort_o = abort_req_i && !abort_hidden;
endmodule

/* src/mfe_pkg.sv */
// shared constants and carriers for the memory fault and event reporting block
package mfe_pkg;
   // apb register byte offsets
   localparam logic [7:0] MFE_CAUSE_OFS = 8'h00;
   localparam logic [7:0] MFE_CTRL_OFS = 8'h04;
   localparam logic [7:0] MFE_INIT_OFS = 8'h08;
   localparam logic [7:0] MFE_GAP_OFS = 8'h0C;
   localparam logic [7:0] MFE_TO_ADDR_OFS = 8'h10;
   localparam logic [7:0] MFE_TO_INFO_OFS = 8'h14;
   localparam logic [7:0] MFE_MOD_ADDR_OFS = 8'h18;
   localparam logic [7:0] MFE_MOD_INFO_OFS = 8'h1C;
   localparam logic [7:0] MFE_PLL_OFS = 8'h20;

   // memory_error_cause_register fields
   localparam int MFE_CAUSE_W = 6;
   localparam int MFE_C_RAM_1B = 0;
   localparam int MFE_C_RAM_2B = 1;
   localparam int MFE_C_ICACHE = 2;
   localparam int MFE_C_ITAG = 3;
   localparam int MFE_C_DCACHE = 4;
   localparam int MFE_C_DTAG = 5;

   // ecc_and_parity_enable_ctrl fields
   localparam int MFE_CTRL_W = 3;
   localparam int MFE_E_IPAR = 0;
   localparam int MFE_E_DPAR = 1;
   localparam int MFE_E_TCM_OFF = 2;
   localparam logic [MFE_CTRL_W-1:0] MFE_CTRL_RST = 3'h0;

   // ecc_init_complete_status fields
   localparam int MFE_INIT_W = 3;
   localparam int MFE_I_ITCM = 0;
   localparam int MFE_I_DTCM = 1;
   localparam int MFE_I_RAM = 2;

   // gap flag fields, write one to clear
   localparam int MFE_GAP_W = 6;
   localparam int MFE_G_EXT = 0;
   localparam int MFE_G_PER = 1;
   localparam int MFE_G_SYS = 2;
   localparam int MFE_G_MOD = 3;
   localparam int MFE_G_ITCM = 4;
   localparam int MFE_G_DTCM = 5;

   // initialization sweep time
   localparam int MFE_CLK_KHZ = 40000;
   localparam int MFE_INIT_NS = 16500;
   localparam int MFE_INIT_CYC = (MFE_INIT_NS * MFE_CLK_KHZ) / 1000000;

   localparam int MFE_CHK_W = 5;

   typedef struct packed {
      logic valid;
      logic write;
      logic [3:0] master;
      logic [31:0] addr;
   } mfe_gap_s;

   typedef struct packed {
      logic valid;
      logic [31:0] data;
      logic [3:0] par;
      logic tag_valid;
      logic [21:0] tag;
      logic tag_par;
   } mfe_cache_rd_s;
endpackage

/* src/mfe_byte_edc.sv */
// single-error-correcting, double-error-detecting code for one byte
`timescale 1ns/1ps
module mfe_byte_edc
   import mfe_pkg::*;
(
   input wire logic [7:0] wdata_i,
   output logic [MFE_CHK_W-1:0] wchk_o,
   input wire logic [7:0] rdata_i,
   input wire logic [MFE_CHK_W-1:0] rchk_i,
   output logic [7:0] fixed_o,
   output logic single_o,
   output logic double_o
);
   // hamming positions 3..12 of the data bits
   localparam logic [3:0] DPOS [8] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC};

   always_comb begin
      logic [3:0] s;
      logic [3:0] syn;
      logic ovp;
      s = 4'h0;
      syn = rchk_i[3:0];
      ovp = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (wdata_i[i]) begin
            s = s ^ DPOS[i];
         end
         if (rdata_i[i]) begin
            syn = syn ^ DPOS[i];
         end
      end
      wchk_o = {(^wdata_i) ^ (^s), s};
      ovp = (^rdata_i) ^ (^rchk_i);
      fixed_o = rdata_i;
      for (int i = 0; i < 8; i++) begin
         if (ovp && syn == DPOS[i]) begin
            fixed_o[i] = ~rdata_i[i];
         end
      end
      // a syndrome beyond the codeword with odd parity is not a single flip
      single_o = ovp && (syn <= 4'hC);
      double_o = (!ovp && syn != 4'h0) || (ovp && syn > 4'hC);
   end
endmodule

/* tb/mfe_top_assertions.sv */
// port-level assertion checker for the fault reporting unit
`timescale 1ns/1ps
module mfe_top_chk
   import mfe_pkg::*;
#(
   parameter int INIT_CYCLES = MFE_INIT_CYC
)(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic tcm_rd_i,
   input wire logic tcm_is_data_i,
   input wire logic undef_data_o,
   input wire logic ram_rd_i,
   input wire mfe_cache_rd_s icache_i,
   input wire mfe_cache_rd_s dcache_i,
   input wire mfe_gap_s ext_gap_i,
   input wire mfe_gap_s sys_gap_i,
   input wire logic init_we_o,
   input wire logic [15:0] init_addr_o,
   input wire logic pll_out_of_range_i,
   input wire logic abort_req_i,
   input wire logic refill_i,
   input wire logic prefetch_abort_o,
   input wire logic memory_error_interrupt_o,
   input wire logic pll_loss_interrupt_o,
   input wire logic ext_mem_gap_interrupt_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   wire logic wr0 = psel_i && penable_i && pwrite_i && paddr_i == MFE_CAUSE_OFS && pwdata_i == 32'h0;
   // a new cause in the clearing cycle still sets, so the clear check needs quiet inputs
   wire logic quiet = !ram_rd_i && !icache_i.valid && !icache_i.tag_valid && !dcache_i.valid && !dcache_i.tag_valid;
   a_irq_level: assert property (memory_error_interrupt_o && !wr0 |=> memory_error_interrupt_o)
      else $error("memory error interrupt dropped");
   a_clear_zero: assert property (wr0 && quiet |=> !memory_error_interrupt_o)
      else $error("cause not cleared by zero write");
   a_undef_data: assert property (undef_data_o |-> $past(tcm_rd_i && tcm_is_data_i))
      else $error("data exception without data memory read");
   a_ext_gap: assert property (ext_gap_i.valid |=> ext_mem_gap_interrupt_o)
      else $error("external gap interrupt missing");
   a_pll_loss: assert property (pll_loss_interrupt_o == pll_out_of_range_i)
      else $error("pll interrupt mismatch");
   a_no_abort: assert property (abort_req_i && refill_i && sys_gap_i.valid |-> !prefetch_abort_o)
      else $error("abort not suppressed on refill error");
   a_abort_pass: assert property (abort_req_i && !refill_i |-> prefetch_abort_o)
      else $error("abort lost");
   a_init_end: assert property ($fell(init_we_o) |-> $past(init_addr_o) == INIT_CYCLES - 1)
      else $error("init sweep length wrong");
endmodule

bind mfe_top mfe_top_chk #(.INIT_CYCLES(INIT_CYCLES)) i_chk (.clk_i(clk_i), .resetn_i(resetn_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .tcm_rd_i(tcm_rd_i), .tcm_is_data_i(tcm_is_data_i), .undef_data_o(undef_data_o), .ram_rd_i(ram_rd_i),
   .icache_i(icache_i), .dcache_i(dcache_i), .ext_gap_i(ext_gap_i), .sys_gap_i(sys_gap_i),
   .init_we_o(init_we_o), .init_addr_o(init_addr_o), .pll_out_of_range_i(pll_out_of_range_i),
   .abort_req_i(abort_req_i), .refill_i(refill_i), .prefetch_abort_o(prefetch_abort_o),
   .memory_error_interrupt_o(memory_error_interrupt_o), .pll_loss_interrupt_o(pll_loss_interrupt_o),
   .ext_mem_gap_interrupt_o(ext_mem_gap_interrupt_o));

/* tb/mfe_irq_model.sv */
// interrupt controller stand-in: each line stays pending until acknowledged
`timescale 1ns/1ps
module mfe_irq_model (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [7:0] irq_i,
   input wire logic ack_i,
   output logic [7:0] pend_o
);
   // level lines re-pend on ack while their cause is still set
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) pend_o <= 8'h00;
      else if (ack_i) pend_o <= irq_i;
      else pend_o <= pend_o | irq_i;
   end
endmodule

/* tb/memory_fault_event_reporting_test.sv */
// self-checking bench for the memory fault and event reporting unit
`timescale 1ns/1ps
module memory_fault_event_reporting_test;
   import mfe_pkg::*;
   localparam int INIT = 8;
   logic clk_i, resetn_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0, tcm_rd_i = 1'h0, ack = 1'h0;
   logic tcm_is_data_i = 1'h0, ram_rd_i = 1'h0, itcm_gap_i = 1'h0, dtcm_gap_i = 1'h0, pll_lock_i = 1'h1;
   logic pll_out_of_range_i = 1'h0, abort_req_i = 1'h0, refill_i = 1'h0, pready_o, pslverr_o, err;
   logic init_we_o, prefetch_abort_o, undef_instr_o, undef_data_o, mem_irq, pll_irq;
   logic [7:0] paddr_i = 8'h00;
   logic [7:0] pend;
   logic [31:0] pwdata_i = 32'h0, tcm_rdata_i = 32'h0, ram_rdata_i = 32'h0, wdata_i = 32'h0;
   logic [31:0] prdata_o, rd, tcm_fixed_o, ram_fixed_o, w;
   logic [19:0] tcm_rchk_i = 20'h0, ram_rchk_i = 20'h0, wchk_o, c;
   logic [15:0] init_addr_o;
   logic [5:0] girq;
   logic [3:0] mod_id_i = 4'h0;
   mfe_cache_rd_s icache_i = '0, dcache_i = '0;
   mfe_gap_s gap [4] = '{default: '0};
   integer err_count = 0, total_checks = 0, seed = 32'hEBF25AAF, cyc = 0, m_cause = 0, m_gap = 0, i;

   mfe_top #(.INIT_CYCLES(INIT)) i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .tcm_rd_i(tcm_rd_i), .tcm_is_data_i(tcm_is_data_i),
      .tcm_rdata_i(tcm_rdata_i), .tcm_rchk_i(tcm_rchk_i), .tcm_fixed_o(tcm_fixed_o), .undef_instr_o(undef_instr_o),
      .undef_data_o(undef_data_o), .ram_rd_i(ram_rd_i), .ram_rdata_i(ram_rdata_i), .ram_rchk_i(ram_rchk_i),
      .ram_fixed_o(ram_fixed_o), .wdata_i(wdata_i), .wchk_o(wchk_o), .init_we_o(init_we_o),
      .init_addr_o(init_addr_o), .icache_i(icache_i), .dcache_i(dcache_i), .ext_gap_i(gap[0]), .per_gap_i(gap[1]),
      .sys_gap_i(gap[2]), .mod_gap_i(gap[3]), .mod_id_i(mod_id_i), .itcm_gap_i(itcm_gap_i), .dtcm_gap_i(dtcm_gap_i),
      .pll_out_of_range_i(pll_out_of_range_i), .pll_lock_i(pll_lock_i), .abort_req_i(abort_req_i),
      .refill_i(refill_i), .prefetch_abort_o(prefetch_abort_o), .memory_error_interrupt_o(mem_irq),
      .pll_loss_interrupt_o(pll_irq), .ext_mem_gap_interrupt_o(girq[0]), .periph_bus_gap_interrupt_o(girq[1]),
      .system_bus_gap_interrupt_o(girq[2]), .module_gap_interrupt_o(girq[3]), .itcm_gap_interrupt_o(girq[4]),
      .dtcm_gap_interrupt_o(girq[5]));
   mfe_irq_model i_icu (.clk_i(clk_i), .resetn_i(resetn_i), .irq_i({mem_irq, pll_irq, girq}), .ack_i(ack),
      .pend_o(pend));

   initial begin
      clk_i = 1'h0;
      forever #12.5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         finish_test;
      end
   end

   task finish_test;
      if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // entered right after a rising edge; leaves one idle edge behind the access
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel_i <= 1'h1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'h1;
      do @(posedge clk_i); while (pready_o !== 1'h1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'h0;
      penable_i <= 1'h0;
      @(posedge clk_i);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(rd, e);
   endtask

   // p: 0 other ram, 1 instruction tcm, 2 data tcm; dbl flips two bits of one byte
   task automatic ecc(input int p, input int dbl, input int off);
      logic [31:0] m;
      logic [4:0] b;
      logic [1:0] k;
      w = $random(seed);
      b = 5'($random(seed));
      k = 2'($random(seed));
      wdata_i <= w;
      @(posedge clk_i);
      c = wchk_o;
      m = (32'h1 << {k, b[2:0]}) | (dbl ? (32'h1 << {k, b[2:1], ~b[0]}) : 32'h0);
      ram_rd_i <= (p == 0);
      tcm_rd_i <= (p != 0);
      tcm_is_data_i <= (p == 2);
      ram_rdata_i <= w ^ m;
      tcm_rdata_i <= w ^ m;
      ram_rchk_i <= c;
      tcm_rchk_i <= c;
      @(posedge clk_i);
      ram_rd_i <= 1'h0;
      tcm_rd_i <= 1'h0;
      @(posedge clk_i);
      if (p == 0) m_cause |= 1 << (dbl ? MFE_C_RAM_2B : MFE_C_RAM_1B);
      if (!dbl) chk(p == 0 ? ram_fixed_o : tcm_fixed_o, off ? w ^ m : w);
      chk({undef_instr_o, undef_data_o}, (dbl && p != 0) ? (p == 1 ? 2 : 1) : 0);
      rc(MFE_CAUSE_OFS, m_cause);
   endtask

   // s: 0 icache data, 1 icache tag, 2 dcache data, 3 dcache tag
   task automatic par(input int s, input int en);
      mfe_cache_rd_s v;
      v = '0;
      v.data = $random(seed);
      v.tag = 22'($random(seed));
      for (int j = 0; j < 4; j++) v.par[j] = ^v.data[8*j+:8];
      v.tag_par = ~(^v.tag);
      v.tag_valid = s[0];
      v.valid = !s[0];
      if (!s[0]) v.par[v.data[1:0]] = ~v.par[v.data[1:0]];
      if (s < 2) icache_i <= v;
      else dcache_i <= v;
      @(posedge clk_i);
      icache_i <= '0;
      dcache_i <= '0;
      @(posedge clk_i);
      if (en) m_cause |= 1 << (MFE_C_ICACHE + s);
      rc(MFE_CAUSE_OFS, m_cause);
   endtask

   task automatic gp(input int g);
      mfe_gap_s v;
      logic [3:0] id;
      v.valid = 1'h1;
      v.write = 1'($random(seed));
      v.master = 4'($random(seed));
      v.addr = $random(seed);
      id = 4'($random(seed));
      mod_id_i <= id;
      if (g < 4) gap[g] <= v;
      itcm_gap_i <= (g == 4);
      dtcm_gap_i <= (g == 5);
      @(posedge clk_i);
      if (g < 4) gap[g] <= '0;
      itcm_gap_i <= 1'h0;
      dtcm_gap_i <= 1'h0;
      @(posedge clk_i);
      m_gap = 1 << g;
      chk(girq, m_gap);
      rc(MFE_GAP_OFS, m_gap);
      if (g < 3) begin
         rc(MFE_TO_ADDR_OFS, v.addr);
         rc(MFE_TO_INFO_OFS, (g << 6) | (v.write << 5) | v.master);
      end
      if (g == 3) begin
         rc(MFE_MOD_ADDR_OFS, v.addr);
         rc(MFE_MOD_INFO_OFS, (id << 4) | (v.write << 3));
      end
      apb(1'h1, MFE_GAP_OFS, m_gap);
      rc(MFE_GAP_OFS, 32'h0);
   endtask

   initial begin
      repeat (12) @(posedge clk_i);
      resetn_i <= 1'h1;
      @(posedge clk_i);
      chk(init_we_o, 1);
      for (i = 0; i < 100 && init_we_o !== 1'h0; i++) @(posedge clk_i);
      rc(MFE_INIT_OFS, 32'h7);
      rc(MFE_CTRL_OFS, 32'h0);
      rc(MFE_PLL_OFS, 32'h1);
      pll_out_of_range_i <= 1'h1;
      rc(MFE_PLL_OFS, 32'h3);
      pll_lock_i <= 1'h0;
      rc(MFE_PLL_OFS, 32'h2);
      pll_lock_i <= 1'h1;
      ecc(0, 0, 0);
      ecc(0, 1, 0);
      ecc(1, 0, 0);
      ecc(1, 1, 0);
      ecc(2, 1, 0);
      apb(1'h1, MFE_CTRL_OFS, 32'h4);
      ecc(2, 0, 1);
      ecc(0, 0, 0);
      apb(1'h1, MFE_CAUSE_OFS, 32'h3F);
      rc(MFE_CAUSE_OFS, m_cause);
      apb(1'h1, MFE_CAUSE_OFS, 32'h0);
      m_cause = 0;
      chk(mem_irq, 0);
      for (i = 0; i < 4; i++) par(i, 0);
      // caches count as swept here, so arming parity is now safe
      apb(1'h1, MFE_CTRL_OFS, 32'h3);
      for (i = 0; i < 4; i++) par(i, 1);
      chk(mem_irq, 1);
      for (i = 0; i < 6; i++) gp(i);
      apb(1'h0, 8'h40, 32'h0);
      chk(err, 32'h1);
      chk(rd, 32'h0);
      apb(1'h1, MFE_INIT_OFS, 32'h0);
      rc(MFE_INIT_OFS, 32'h7);
      abort_req_i <= 1'h1;
      refill_i <= 1'h1;
      gap[2].valid <= 1'h1;
      @(posedge clk_i);
      chk(prefetch_abort_o, 0);
      gap[2].valid <= 1'h0;
      refill_i <= 1'h0;
      @(posedge clk_i);
      chk(prefetch_abort_o, 1);
      abort_req_i <= 1'h0;
      pll_out_of_range_i <= 1'h0;
      chk(pend, 8'hFF);
      apb(1'h1, MFE_CAUSE_OFS, 32'h0);
      apb(1'h1, MFE_GAP_OFS, 32'h3F);
      ack <= 1'h1;
      @(posedge clk_i);
      ack <= 1'h0;
      @(posedge clk_i);
      chk(pend, 8'h00);
      finish_test;
   end
endmodule
